// ### design/alarm_consts.vh
// Constants for the input alarm threshold register bank.
// Included by every design file but the sticky_flag module; definitions only.
`ifndef ALARM_CONSTS_VH
`define ALARM_CONSTS_VH
`define ADDR_W              8
`define OFF_UPPER_CFG       8'h24
`define OFF_LOWER_CFG       8'h28
`define OFF_INT_STATUS      8'h30
`define OFF_INT_MASK        8'h34
`define OFF_ALARM_STATE     8'h38
`define UPPER_CFG_RESET     32'h0000FFFF
`define LOWER_CFG_RESET     32'h00000000
`define HYST_RESET          8'h00
`define UPPER_LIMIT_RESET   16'hFFFF
`define LOWER_LIMIT_RESET   16'h0000
`define HYST_HI             31
`define HYST_LO             24
`define HYST_USE_LO         28
`define LIMIT_HI            15
`define LIMIT_LO            0
`define LIMIT_USE_LO        2
`define CODE_W              14
`define HYST_W              4
`define INT_W               2
`define INT_BIT_UPPER       0
`define INT_BIT_LOWER       1
`define ST_ACTIVE_UPPER     10
`define ST_ACTIVE_LOWER     11
`define ST_TRIP_UPPER       4
`define ST_TRIP_LOWER       5
`define ST_SUMMARY          0
`endif

// ### design/limit_compare.v
// One hysteresis comparator for an input alarm.
// Assumes code, limit and hysteresis are on the clk domain.
`timescale 1ns/1ps
`include "alarm_consts.vh"
module limit_compare #(
  parameter UPPER = 1
) (
  input  wire                   clk,
  input  wire                   rst,
  input  wire                   sample,
  input  wire [`CODE_W-1:0]     code,
  input  wire [`CODE_W-1:0]     limit,
  input  wire [`HYST_W-1:0]     hyst,
  output reg                    active
);
  wire [`CODE_W:0] code_x;
  wire [`CODE_W:0] limit_x;
  wire [`CODE_W:0] hyst_x;
  wire             trip;
  wire             release_ok;
  assign code_x  = {1'b0, code};
  assign limit_x = {1'b0, limit};
  assign hyst_x  = {{(`CODE_W+1-`HYST_W){1'b0}}, hyst};
  // Raise beyond limit; release once back past limit by hysteresis
  assign trip = UPPER ? (code_x > limit_x) : (code_x < limit_x);
  assign release_ok = UPPER ? (code_x + hyst_x <= limit_x)
                            : (code_x >= limit_x + hyst_x);
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      active <= 1'b0;
    else if (sample)
    begin
      if (trip)
        active <= 1'b1;
      else if (release_ok)
        active <= 1'b0;
    end
  end
endmodule // limit_compare

// ### design/sticky_flag.v
// One sticky status bit: hardware sets, software clears by writing one.
// Assumes set and clear come from logic on clk.
`timescale 1ns/1ps
module sticky_flag (
  input  wire clk,
  input  wire rst,
  input  wire set,
  input  wire clear,
  output reg  flag
);
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      flag <= 1'b0;
    else if (set)
      flag <= 1'b1;
    else if (clear)
      flag <= 1'b0;
  end
endmodule // sticky_flag

// ### design/input_alarm_threshold_regs.v
// Input alarm threshold registers with APB access and alarm compare.
// Assumes APB master and conversion source on clk; result_valid pulses.
//
// Summary of operation
// - Upper-limit config register sits at byte address 24h, bits 7-0 low.
// - Upper-limit register holds hysteresis and the upper limit.
// - Bits 31-24 hold hysteresis, reset 00h, only bits 31-28 used.
// - Bits 23-16 of the upper-limit register read zero and ignore writes.
// - Upper limit is bits 15-0, reset FFFFh, compare uses bits 15-2.
// - Lower-limit config register sits at byte address 28h, bits 7-0 low.
// - Lower-limit register holds only the lower limit; bits 31-16 read 0.
// - Lower limit is bits 15-0, reset 0, compare uses bits 15-2.
// - Summary flag is one when any tripped flag is set; the summary output follows one cycle later.
// - Active and tripped flags are separate; active flags are read-only, tripped flags clear by writing one.
`timescale 1ns/1ps
`include "alarm_consts.vh"
module input_alarm_threshold_regs (
  input  wire                   clk,
  input  wire                   rst,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [31:0]            paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  input  wire                   result_valid,
  input  wire [`CODE_W-1:0]     result_code,
  output reg                    active_upper,
  output reg                    active_lower,
  output reg                    overall_alarm_summary,
  output reg                    irq
);
  reg  [7:0]            input_alarm_hysteresis;
  reg  [15:0]           input_alarm_upper_limit;
  reg  [15:0]           input_alarm_lower_limit;
  reg  [`INT_W-1:0]     int_mask;
  reg  [31:0]           next_prdata;
  reg                   next_pslverr;
  wire                  setup;
  wire                  wr;
  wire                  mapped;
  wire [`ADDR_W-1:0]    addr;
  wire                  cmp_upper;
  wire                  cmp_lower;
  wire                  rise_upper;
  wire                  rise_lower;
  wire [`INT_W-1:0]     tripped;
  wire [`INT_W-1:0]     clear_bits;
  reg                   cmp_upper_q;
  reg                   cmp_lower_q;
  reg  [1:0]            bus_state;
  reg  [1:0]            next_bus_state;
  reg  [31:0]           state_word;
  wire                  in_page;
  wire                  sel_upper;
  wire                  sel_lower;
  wire                  sel_status;
  wire                  sel_mask;
  wire                  sel_state;
  wire                  wr_upper;
  wire                  wr_lower;
  wire                  wr_status;
  wire                  wr_mask;
  wire [`HYST_W-1:0]    hyst_used;
  wire [`CODE_W-1:0]    upper_used;
  wire [`CODE_W-1:0]    lower_used;
  wire [31:0]           upper_word;
  wire [31:0]           lower_word;
  wire [31:0]           status_word;
  wire [31:0]           mask_word;

  // Bus answer states, one-hot
  localparam [1:0] BUS_IDLE   = 2'h1;
  localparam [1:0] BUS_ANSWER = 2'h2;

  assign addr   = paddr[`ADDR_W-1:0];
  assign setup  = psel & ~penable;

  // One select per register; the address bits above the page must be 0
  assign in_page    = (paddr[31:`ADDR_W] == {(32-`ADDR_W){1'b0}});
  assign sel_upper  = in_page && (addr == `OFF_UPPER_CFG);
  assign sel_lower  = in_page && (addr == `OFF_LOWER_CFG);
  assign sel_status = in_page && (addr == `OFF_INT_STATUS);
  assign sel_mask   = in_page && (addr == `OFF_INT_MASK);
  assign sel_state  = in_page && (addr == `OFF_ALARM_STATE);
  assign mapped     = sel_upper | sel_lower | sel_status | sel_mask |
                      sel_state;

  // Writes take effect at the access edge, where pready is high
  assign wr        = psel & penable & pready & pwrite & mapped;
  assign wr_upper  = wr & sel_upper;
  assign wr_lower  = wr & sel_lower;
  assign wr_status = wr & sel_status;
  assign wr_mask   = wr & sel_mask;

  // Hysteresis byte: all eight bits are kept, the top four compare
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      input_alarm_hysteresis <= `HYST_RESET;
    else if (wr_upper)
      input_alarm_hysteresis <= pwdata[`HYST_HI:`HYST_LO];
  end

  // Upper limit: bits 1-0 are kept for read-back but never compared
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      input_alarm_upper_limit <= `UPPER_LIMIT_RESET;
    else if (wr_upper)
      input_alarm_upper_limit <= pwdata[`LIMIT_HI:`LIMIT_LO];
  end

  // Lower limit: the upper half of the word is not stored
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      input_alarm_lower_limit <= `LOWER_LIMIT_RESET;
    else if (wr_lower)
      input_alarm_lower_limit <= pwdata[`LIMIT_HI:`LIMIT_LO];
  end

  // Interrupt mask, one bit per tripped flag
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      int_mask <= {`INT_W{1'b0}};
    else if (wr_mask)
      int_mask <= pwdata[`INT_W-1:0];
  end

  // Only the upper 14 limit bits and upper 4 hysteresis bits compare
  assign upper_used = input_alarm_upper_limit[`LIMIT_HI:`LIMIT_USE_LO];
  assign lower_used = input_alarm_lower_limit[`LIMIT_HI:`LIMIT_USE_LO];
  assign hyst_used  = input_alarm_hysteresis[`HYST_HI-`HYST_LO:
                                             `HYST_USE_LO-`HYST_LO];

  // Comparators on the 14 used limit bits and 4 used hysteresis bits
  limit_compare #(.UPPER(1)) u_cmp_upper (
    .clk    (clk),
    .rst    (rst),
    .sample (result_valid),
    .code   (result_code),
    .limit  (upper_used),
    .hyst   (hyst_used),
    .active (cmp_upper)
  );
  limit_compare #(.UPPER(0)) u_cmp_lower (
    .clk    (clk),
    .rst    (rst),
    .sample (result_valid),
    .code   (result_code),
    .limit  (lower_used),
    .hyst   (hyst_used),
    .active (cmp_lower)
  );

  // Previous comparator state, for onset detection
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmp_upper_q <= 1'b0;
      cmp_lower_q <= 1'b0;
    end
    else
    begin
      cmp_upper_q <= cmp_upper;
      cmp_lower_q <= cmp_lower;
    end
  end
  assign rise_upper = cmp_upper & ~cmp_upper_q;
  assign rise_lower = cmp_lower & ~cmp_lower_q;

  // Tripped flags latch alarm onsets until software writes a one
  assign clear_bits = wr_status ?
                      pwdata[`INT_W-1:0] : {`INT_W{1'b0}};
  sticky_flag u_trip_upper (
    .clk   (clk),
    .rst   (rst),
    .set   (rise_upper),
    .clear (clear_bits[`INT_BIT_UPPER]),
    .flag  (tripped[`INT_BIT_UPPER])
  );
  sticky_flag u_trip_lower (
    .clk   (clk),
    .rst   (rst),
    .set   (rise_lower),
    .clear (clear_bits[`INT_BIT_LOWER]),
    .flag  (tripped[`INT_BIT_LOWER])
  );

  // Registered status outputs
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      active_upper          <= 1'b0;
      active_lower          <= 1'b0;
      overall_alarm_summary <= 1'b0;
    end
    else
    begin
      active_upper          <= cmp_upper;
      active_lower          <= cmp_lower;
      overall_alarm_summary <= |tripped;
    end
  end

  // Level interrupt: high while any unmasked tripped flag is set
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(tripped & int_mask);
  end

  // Read images; reserved bits are tied to zero
  assign upper_word  = {input_alarm_hysteresis,
                        {(`HYST_LO-`LIMIT_HI-1){1'b0}},
                        input_alarm_upper_limit};
  assign lower_word  = {{(31-`LIMIT_HI){1'b0}},
                        input_alarm_lower_limit};
  assign status_word = {{(32-`INT_W){1'b0}}, tripped};
  assign mask_word   = {{(32-`INT_W){1'b0}}, int_mask};

  // Alarm state image, a mirror of comparators and tripped flags
  always @*
  begin
    state_word                   = 32'h00000000;
    state_word[`ST_ACTIVE_UPPER] = cmp_upper;
    state_word[`ST_ACTIVE_LOWER] = cmp_lower;
    state_word[`ST_TRIP_UPPER]   = tripped[`INT_BIT_UPPER];
    state_word[`ST_TRIP_LOWER]   = tripped[`INT_BIT_LOWER];
    state_word[`ST_SUMMARY]      = |tripped;
  end

  // Read data mux; unmapped addresses read zero and flag an error
  always @*
  begin
    next_prdata  = 32'h00000000;
    next_pslverr = ~mapped;
    case (addr)
      `OFF_UPPER_CFG:
        next_prdata = upper_word;
      `OFF_LOWER_CFG:
        next_prdata = lower_word;
      `OFF_INT_STATUS:
        next_prdata = status_word;
      `OFF_INT_MASK:
        next_prdata = mask_word;
      `OFF_ALARM_STATE:
        next_prdata = state_word;
      default:
        next_prdata = 32'h00000000;
    endcase
    if (!mapped)
      next_prdata = 32'h00000000;
  end

  // Bus sequencer: each setup cycle is answered in the next cycle, so a
  // transfer always has exactly one access cycle and no wait state
  always @*
  begin
    next_bus_state = BUS_IDLE;
    case (bus_state)
      BUS_IDLE:
        if (setup)
          next_bus_state = BUS_ANSWER;
      BUS_ANSWER:
        if (setup)
          next_bus_state = BUS_ANSWER;
      default:
        next_bus_state = BUS_IDLE;
    endcase
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      bus_state <= BUS_IDLE;
    else
      bus_state <= next_bus_state;
  end

  // APB answer: pready, pslverr and prdata stand for the access cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else if (next_bus_state == BUS_ANSWER)
    begin
      pready  <= 1'b1;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
  end
endmodule // input_alarm_threshold_regs

// ### testbench/alarm_props_properties.sv
// Port checker for the alarm threshold register bank.
// Assumes it is bound to input_alarm_threshold_regs.
`timescale 1ns/1ps
`include "alarm_consts.vh"
module alarm_props (
  input logic        clk,
  input logic        rst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        result_valid,
  input logic        active_upper,
  input logic        active_lower,
  input logic        overall_alarm_summary,
  input logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [7:0] lo = paddr[7:0];
  wire ok = paddr[31:8] == 24'h0 && (lo == `OFF_UPPER_CFG ||
    lo == `OFF_LOWER_CFG || lo == `OFF_INT_STATUS ||
    lo == `OFF_INT_MASK || lo == `OFF_ALARM_STATE);
  wire rd_ans = pready && !pwrite;
  sequence setup_s;
    psel && !penable;
  endsequence
  answer_a: assert property (setup_s |=> pready)
    else $error("no answer");
  pulse_a: assert property (pready |=> !pready)
    else $error("long answer");
  idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("data while idle");
  upper_rsvd_a: assert property (rd_ans && lo == `OFF_UPPER_CFG
    |-> prdata[23:16] == 8'h00) else $error("upper reserved set");
  lower_rsvd_a: assert property (rd_ans && lo == `OFF_LOWER_CFG
    |-> prdata[31:16] == 16'h0000) else $error("lower reserved set");
  bad_addr_a: assert property (setup_s ##0 !ok |=> pslverr)
    else $error("no error");
  good_addr_a: assert property (setup_s ##0 ok |=> !pslverr)
    else $error("false error");
  trip_sum_a: assert property ($rose(active_upper) ||
    $rose(active_lower) |=> overall_alarm_summary) else $error("no sum");
  act_cause_a: assert property ($changed({active_upper,
    active_lower}) |-> $past(result_valid, 1) || $past(result_valid, 2))
    else $error("alarm moved alone");
  irq_sum_a: assert property (irq |-> overall_alarm_summary)
    else $error("irq without sum");
endmodule // alarm_props
bind input_alarm_threshold_regs alarm_props i_alarm_props (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .result_valid(result_valid),
  .active_upper(active_upper), .active_lower(active_lower),
  .overall_alarm_summary(overall_alarm_summary), .irq(irq));

// ### testbench/apb_host.sv
// Host model that programs the threshold registers over APB.
// Assumes one clock shared with the slave.
`timescale 1ns/1ps
`include "alarm_consts.vh"
module apb_host (
  input  wire        clk,
  input  wire        pready,
  input  wire        pslverr,
  input  wire [31:0] prdata,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [31:0] paddr,
  output reg  [31:0] pwdata,
  output reg         hung
);
  initial
  begin
    {psel, penable, pwrite, hung} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  task xfer(input [31:0] a, input w, input [31:0] d,
            output [31:0] q, output e);
    integer      n;
    reg   [31:0] v;
    begin
      v = d;
      if (a == `OFF_UPPER_CFG)
        v = d & 32'hF0FFFFFC;
      else if (a == `OFF_LOWER_CFG)
        v = d & 32'hFFFFFFFC;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
        n = n + 1;
        @(posedge clk);
      end
      hung = n >= 20;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~v;
    end
  endtask
endmodule // apb_host

// ### testbench/test_input_alarm_threshold_regs.sv
// Bench for the alarm threshold registers with a host model.
// Assumes design/ on the include path.
`timescale 1ns/1ps
`include "alarm_consts.vh"
module test_input_alarm_threshold_regs;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, hung, e;
  logic [31:0] paddr, pwdata, prdata, q;
  logic        result_valid, active_upper, active_lower, irq;
  logic        overall_alarm_summary;
  logic [13:0] result_code;
  integer      bad_count = 0, num_checks = 0, i;
  logic [13:0] cv [0:7] = '{14'h1000, 14'h1001, 14'h0FFF, 14'h0FFE,
                            14'h0200, 14'h01FF, 14'h0201, 14'h0202};
  logic [1:0]  ev [0:7] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0};
  input_alarm_threshold_regs i_input_alarm_threshold_regs (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .result_valid(result_valid),
    .result_code(result_code), .active_upper(active_upper),
    .active_lower(active_lower), .irq(irq),
    .overall_alarm_summary(overall_alarm_summary));
  apb_host i_apb_host (
    .clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .hung(hung));
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        bad_count = bad_count + 1;
      end
    end
  endtask
  task acc(input [31:0] a, input w, input [31:0] d, input [31:0] x,
           input xe);
    begin
      i_apb_host.xfer(a, w, d, q, e);
      if (hung !== 1'b0)
      begin
        bad_count = bad_count + 1;
        end_of_test;
      end
      else
      begin
        chk(e, xe);
        if (!w)
          chk(q, x);
      end
    end
  endtask
  task conv(input [13:0] c);
    begin
      @(posedge clk);
      result_valid <= 1'b1;
      result_code <= c;
      @(posedge clk);
      result_valid <= 1'b0;
      result_code <= ~c;
      repeat (3) @(posedge clk);
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    result_valid = 1'b0;
    result_code = 14'h0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    acc(`OFF_UPPER_CFG, 0, 0, `UPPER_CFG_RESET, 0);
    acc(`OFF_LOWER_CFG, 0, 0, `LOWER_CFG_RESET, 0);
    acc(`OFF_INT_MASK, 0, 0, 32'h0, 0);
    acc(`OFF_UPPER_CFG, 1, 32'h25AB4003, 0, 0);
    acc(`OFF_UPPER_CFG, 0, 0, 32'h20004000, 0);
    acc(`OFF_LOWER_CFG, 1, 32'hFFFF0803, 0, 0);
    acc(`OFF_LOWER_CFG, 0, 0, 32'h00000800, 0);
    acc(32'h3C, 1, 32'hFFFFFFFF, 0, 1);
    acc(32'h3C, 0, 0, 32'h0, 1);
    for (i = 0; i < 8; i = i + 1)
    begin
      conv(cv[i]);
      chk({active_lower, active_upper}, ev[i]);
    end
    chk(overall_alarm_summary, 1);
    acc(`OFF_ALARM_STATE, 0, 0, 32'h00000031, 0);
    acc(`OFF_INT_STATUS, 0, 0, 32'h3, 0);
    chk(irq, 0);
    acc(`OFF_INT_MASK, 1, 32'h3, 0, 0);
    acc(`OFF_INT_MASK, 0, 0, 32'h3, 0);
    acc(`OFF_INT_STATUS, 1, 32'h1, 0, 0);
    acc(`OFF_INT_STATUS, 0, 0, 32'h2, 0);
    chk(irq, 1);
    acc(`OFF_INT_STATUS, 1, 32'h2, 0, 0);
    acc(`OFF_ALARM_STATE, 0, 0, 32'h0, 0);
    chk({irq, overall_alarm_summary}, 0);
    end_of_test;
  end
endmodule // test_input_alarm_threshold_regs
